// file: pkg/azfm_params.svh
// constants of the audio zero-crossing frequency meter: offsets, fields, defaults, scaling
`ifndef AZFM_PARAMS_SVH
`define AZFM_PARAMS_SVH

`define AZFM_OFF_MINC 8'h00
`define AZFM_OFF_MINS 8'h04
`define AZFM_OFF_THR 8'h08
`define AZFM_OFF_STAT 8'h0C
`define AZFM_OFF_FREQ 8'h10
`define AZFM_OFF_CNT 8'h14

`define AZFM_MINC_RST 16'h0001
`define AZFM_MINS_RST 16'h01E0
`define AZFM_RISE_RST 7'h50
`define AZFM_FALL_RST 7'h3C

`define AZFM_THR_RISE_LSB 0
`define AZFM_THR_FALL_LSB 8
`define AZFM_STAT_KEYED 0
`define AZFM_STAT_BUSY 1
`define AZFM_STAT_TXKEY 2

`define AZFM_RATE_SPS 64'h0000_0000_0000_BB80
`define AZFM_FRAC_BITS 16
`define AZFM_HZ_FRAC_BITS 24
`define AZFM_FRAC_ONE 17'h10000
`define AZFM_PCT_SCALE 24'h01_47AE

`endif

// file: pkg/azfm_pkg.sv
// types of the audio zero-crossing frequency meter
package azfm_pkg;

	typedef enum logic [1:0] {
		AZFM_IDLE,
		AZFM_FRAC,
		AZFM_FREQ
	} azfm_phase_t;

	typedef struct packed {
		azfm_phase_t phase;
		logic [15:0] min_cycles;
		logic [15:0] min_samples;
		logic [6:0] rise_pct;
		logic [6:0] fall_pct;
		logic [23:0] prev;
		logic have_prev;
		logic keyed;
		logic started;
		logic have_freq;
		logic [23:0] peak;
		logic [19:0] cnt;
		logic [19:0] xi;
		logic [15:0] cyc;
		logic [15:0] ended_cyc;
		logic end_meas;
		logic take_f0;
		logic [16:0] f0;
		logic [31:0] freq;
		logic freq_valid;
		logic tx_key;
		logic [15:0] meas_count;
		logic dphase;
		logic [7:0] daddr;
		logic [31:0] hrdata;
		logic ready;
		logic div_start;
		logic [63:0] div_num;
		logic [63:0] div_den;
	} azfm_state_t;

endpackage : azfm_pkg

// file: rtl/azfm_div.sv
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module azfm_div #(
	parameter int W = 64
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic busy,
	output logic done,
	output logic [W-1:0] quo
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [$clog2(W):0] cnt;
		logic [W-1:0] q;
		logic [W-1:0] r;
		logic [W-1:0] d;
	} azfm_div_t;

	azfm_div_t s;
	azfm_div_t next_s;
	logic [W:0] rem;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		rem = {s.r, s.q[W-1]};
		if (start && !s.busy) begin
			next_s.busy = 1'b1;
			next_s.cnt = ($clog2(W)+1)'(W);
			next_s.q = num;
			next_s.r = '0;
			next_s.d = den;
		end else if (s.busy) begin
			next_s.q = {s.q[W-2:0], 1'b0};
			// zero divisor always subtracts, so the quotient saturates to all ones
			if (rem >= {1'b0, s.d}) begin
				next_s.r = W'(rem - {1'b0, s.d});
				next_s.q[0] = 1'b1;
			end else begin
				next_s.r = rem[W-1:0];
			end
			next_s.cnt = s.cnt - 1'b1;
			if (s.cnt == 1) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy = s.busy;
	assign done = s.done;
	assign quo = s.q;
endmodule : azfm_div

// file: rtl/azfm_top.sv
// audio zero-crossing frequency meter with transmit keying and an ahb-lite register slave
//
// Contract
// - crossing instant found by straight-line interpolation between the two neighbouring samples
// - period is whole samples between crossings plus fractional parts at each end
// - sample count is converted to hertz assuming exactly 48000 samples per second
// - minimum cycles and minimum samples are settable, defaults 1 and 480
// - a measurement ends only at a crossing meeting both minimums, averaging all cycles
// - measurement runs continuously and each result updates the transmit frequency
// - cycles ignored and transmitter unkeyed until amplitude reaches rise percent, default 80
// - transmitter unkeyed when amplitude drops below fall percent, default 60
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "azfm_params.svh"
module azfm_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sample_valid,
	input wire logic [23:0] sample_data,
	output logic tx_key,
	output logic [31:0] freq_hz,
	output logic freq_valid
);
	import azfm_pkg::*;

	azfm_state_t s;
	azfm_state_t next_s;
	logic div_busy;
	logic div_done;
	logic [63:0] div_quo;
	logic [23:0] mag;
	logic [23:0] peak_now;
	logic xing;
	logic accept;

	function automatic logic [23:0] azfm_abs(input logic [23:0] x);
		return x[23] ? 24'(-x) : x;
	endfunction : azfm_abs

	function automatic logic [23:0] azfm_level(input logic [6:0] pct);
		return 24'(pct * `AZFM_PCT_SCALE);
	endfunction : azfm_level

	function automatic logic [31:0] azfm_read(input azfm_state_t r, input logic [7:0] a);
		case (a)
			`AZFM_OFF_MINC: return {16'h0000, r.min_cycles};
			`AZFM_OFF_MINS: return {16'h0000, r.min_samples};
			`AZFM_OFF_THR: return {17'h00000, r.fall_pct, 1'b0, r.rise_pct};
			`AZFM_OFF_STAT: return {29'h00000000, r.tx_key, r.phase != AZFM_IDLE, r.keyed};
			`AZFM_OFF_FREQ: return r.freq;
			`AZFM_OFF_CNT: return {16'h0000, r.meas_count};
			default: return 32'h00000000;
		endcase
	endfunction : azfm_read

	azfm_div #(.W(64)) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(s.div_start),
		.num(s.div_num),
		.den(s.div_den),
		.busy(div_busy),
		.done(div_done),
		.quo(div_quo)
	);

	assign mag = azfm_abs(sample_data);
	assign peak_now = (mag > s.peak) ? mag : s.peak;
	// crossings that land while a division runs are dropped; samples come far slower
	assign xing = sample_valid && s.have_prev && s.prev[23] && !sample_data[23]
		&& s.keyed && s.phase == AZFM_IDLE && !div_busy;
	assign accept = hsel && hready && htrans[1];

	always_comb begin
		next_s = s;
		next_s.freq_valid = 1'b0;
		next_s.div_start = 1'b0;
		next_s.ready = 1'b1;
		// bus write lands at the end of its data phase
		if (s.dphase) begin
			case (s.daddr)
				`AZFM_OFF_MINC: next_s.min_cycles = hwdata[15:0];
				`AZFM_OFF_MINS: next_s.min_samples = hwdata[15:0];
				`AZFM_OFF_THR: begin
					next_s.rise_pct = hwdata[`AZFM_THR_RISE_LSB +: 7];
					next_s.fall_pct = hwdata[`AZFM_THR_FALL_LSB +: 7];
				end
				default: ;
			endcase
		end
		next_s.dphase = accept && hwrite;
		next_s.daddr = haddr[7:0];
		if (sample_valid) begin
			next_s.prev = sample_data;
			next_s.have_prev = 1'b1;
			next_s.peak = peak_now;
			next_s.cnt = (&s.cnt) ? s.cnt : s.cnt + 20'h00001;
			if (!s.keyed) begin
				if (mag >= azfm_level(s.rise_pct)) begin
					next_s.keyed = 1'b1;
					next_s.started = 1'b0;
					next_s.peak = 24'h000000;
				end
			end else if (xing) begin
				next_s.peak = 24'h000000;
				if (peak_now < azfm_level(s.fall_pct)) begin
					next_s.keyed = 1'b0;
					next_s.started = 1'b0;
					next_s.have_freq = 1'b0;
				end else begin
					next_s.xi = s.cnt + 20'h00001;
					next_s.end_meas = s.started
						&& (17'(s.cyc) + 17'h00001 >= {1'b0, s.min_cycles})
						&& (s.cnt + 20'h00001 >= {4'h0, s.min_samples});
					next_s.take_f0 = next_s.end_meas || !s.started;
					next_s.ended_cyc = s.cyc + 16'h0001;
					next_s.cyc = next_s.take_f0 ? 16'h0000 : s.cyc + 16'h0001;
					next_s.cnt = next_s.take_f0 ? 20'h00001 : s.cnt + 20'h00001;
					next_s.started = 1'b1;
					// fraction of a sample from the negative sample to the crossing
					next_s.div_num = 64'(azfm_abs(s.prev)) << `AZFM_FRAC_BITS;
					next_s.div_den = 64'(azfm_abs(s.prev)) + 64'(sample_data);
					next_s.div_start = 1'b1;
					next_s.phase = AZFM_FRAC;
				end
			end
		end
		case (s.phase)
			AZFM_FRAC: if (div_done) begin
				if (s.take_f0) begin
					next_s.f0 = div_quo[16:0];
				end
				if (s.end_meas) begin
					// whole samples between the two negative samples, plus the end fraction, minus the start fraction f0
					next_s.div_den = (64'(s.xi - 20'h00001) << `AZFM_FRAC_BITS)
						+ 64'(div_quo[16:0]) - 64'(s.f0);
					next_s.div_num = (64'(s.ended_cyc) * `AZFM_RATE_SPS)
						<< `AZFM_HZ_FRAC_BITS;
					next_s.div_start = 1'b1;
					next_s.phase = AZFM_FREQ;
				end else begin
					next_s.phase = AZFM_IDLE;
				end
			end
			AZFM_FREQ: if (div_done) begin
				next_s.freq = div_quo[31:0];
				next_s.freq_valid = 1'b1;
				next_s.have_freq = next_s.keyed;
				next_s.meas_count = s.meas_count + 16'h0001;
				next_s.phase = AZFM_IDLE;
			end
			AZFM_IDLE: ;
			default: next_s.phase = AZFM_IDLE;
		endcase
		// first result since keying is needed so the carrier never starts off frequency
		next_s.tx_key = next_s.keyed && next_s.have_freq;
		// read from the next state so a read right behind a write sees the new value
		if (accept && !hwrite) begin
			next_s.hrdata = azfm_read(next_s, haddr[7:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.min_cycles <= `AZFM_MINC_RST;
			s.min_samples <= `AZFM_MINS_RST;
			s.rise_pct <= `AZFM_RISE_RST;
			s.fall_pct <= `AZFM_FALL_RST;
			s.phase <= AZFM_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata = s.hrdata;
	assign hreadyout = s.ready;
	assign hresp = 1'b0 & s.ready;
	assign tx_key = s.tx_key;
	assign freq_hz = s.freq;
	assign freq_valid = s.freq_valid;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	frac_in_range_a: assert property (
		s.phase == AZFM_FRAC && div_done |-> div_quo <= 64'(`AZFM_FRAC_ONE))
		else $error("interpolated fraction above one sample");
	period_positive_a: assert property (
		s.div_start && s.phase == AZFM_FREQ
		|-> s.div_den > ((64'(s.xi) - 64'h2) << `AZFM_FRAC_BITS))
		else $error("period shorter than whole sample count");
	rate_numerator_a: assert property (
		s.div_start && s.phase == AZFM_FREQ
		|-> s.div_num == (64'(s.ended_cyc) * 64'h0000_0000_0000_BB80) << 24)
		else $error("frequency numerator not based on 48000 samples per second");
	config_write_a: assert property (
		s.dphase && s.daddr == `AZFM_OFF_MINS |=> s.min_samples == $past(hwdata[15:0]))
		else $error("minimum sample setting not stored");
	end_criteria_a: assert property (
		$rose(s.phase == AZFM_FREQ)
		|-> s.ended_cyc >= s.min_cycles && s.xi >= {4'h0, s.min_samples})
		else $error("measurement ended before both minimums met");
	result_update_a: assert property (
		$rose(s.phase == AZFM_FREQ) |-> ##[64:70] s.freq_valid)
		else $error("completed measurement did not update frequency");
	rise_key_a: assert property (
		$rose(s.keyed) |-> $past(sample_valid && azfm_abs(sample_data) >= azfm_level(s.rise_pct)))
		else $error("keyed without reaching rise level");
	fall_unkey_a: assert property (
		$fell(s.keyed) |-> $past(xing) ##1 !tx_key)
		else $error("unkeyed other than at a crossing below fall level");
	crossing_dir_a: assert property (
		$rose(s.phase == AZFM_FRAC) |-> !s.prev[23] && $past(s.prev[23]))
		else $error("crossing taken in the wrong direction");
endmodule : azfm_top

// file: sim/azfm_src.sv
// audio sample source: triangle tone of settable amplitude, one sample per gap
`timescale 1ns/1ps
module azfm_src #(
	parameter int GAP = 140,
	parameter real PER = 20.25
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [22:0] amp,
	output logic sample_valid,
	output logic [23:0] sample_data
);
	real ph;
	real t;
	int cnt;
	// triangle so straight-line interpolation at the crossing is exact
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			ph = 0.0;
			sample_valid <= 1'b0;
			sample_data <= 24'h0;
		end else if (cnt == GAP - 1) begin
			t = ph < 0.25 ? 4.0 * ph : (ph < 0.75 ? 2.0 - 4.0 * ph : 4.0 * ph - 4.0);
			sample_data <= 24'($rtoi(t * amp));
			sample_valid <= 1'b1;
			cnt <= 0;
			ph = ph + 1.0 / PER;
			if (ph >= 1.0) ph = ph - 1.0;
		end else begin
			cnt <= cnt + 1;
			sample_valid <= 1'b0;
			// data is not held outside the strobe
			if (sample_valid) sample_data <= ~sample_data;
		end
	end
endmodule : azfm_src

// file: sim/tb_top.sv
// self-checking bench for the zero-crossing frequency meter
`timescale 1ns/1ps
`include "azfm_params.svh"
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic sample_valid;
	logic [23:0] sample_data;
	logic tx_key;
	logic [31:0] freq_hz;
	logic freq_valid;
	logic [22:0] amp = 23'h400000;
	logic [31:0] d;
	int err_count = 0;
	int n_checks = 0;
	int nsamp = 0;
	int npulse = 0;
	int cyc = 0;
	always #2.5 hclk = ~hclk;
	azfm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
		.sample_data(sample_data), .tx_key(tx_key), .freq_hz(freq_hz), .freq_valid(freq_valid));
	azfm_src src (.hclk(hclk), .hresetn(hresetn), .amp(amp), .sample_valid(sample_valid),
		.sample_data(sample_data));
	always @(posedge hclk) begin
		if (sample_valid) nsamp <= nsamp + 1;
		if (freq_valid === 1'b1) npulse <= npulse + 1;
		cyc <= cyc + 1;
		// whole run needs about 80k cycles
		if (cyc == 95000) begin
			err_count++;
			stop_test();
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk
	task rng(input string n, input int lo, input int hi, input logic [31:0] s);
		n_checks++;
		if ((s >= lo && s <= hi) !== 1'b1) begin
			$display("BAD %s expected %0d..%0d seen %h", n, lo, hi, s);
			err_count++;
		end
	endtask : rng
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus
	task wait_s(input int n);
		int t;
		t = nsamp + n;
		while (nsamp < t) @(negedge hclk);
	endtask : wait_s
	task wp(output int s);
		do @(negedge hclk); while (freq_valid !== 1'b1);
		s = nsamp;
	endtask : wp
	task t_regs;
		logic [7:0] ad [5] = '{`AZFM_OFF_MINC, `AZFM_OFF_MINS, `AZFM_OFF_THR, `AZFM_OFF_CNT, 8'h18};
		logic [31:0] ex [5] = '{32'h1, 32'h1E0, 32'h3C50, 32'h0, 32'h0};
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ad[i], 32'h0);
			chk("reset reg", ex[i], d);
		end
		bus(1'b1, `AZFM_OFF_MINS, 32'h32);
		bus(1'b0, `AZFM_OFF_MINS, 32'h0);
		chk("mins", 32'h32, d);
	endtask : t_regs
	task t_gate;
		wait_s(60);
		chk("pulses", 32'h0, npulse);
		chk("key low", 32'h0, {31'h0, tx_key});
	endtask : t_gate
	task t_meas;
		int a;
		int b;
		@(posedge hclk);
		amp <= 23'h7FFFFF;
		// gate is open well before the first result can exist
		wait_s(25);
		chk("key early", 32'h0, {31'h0, tx_key});
		bus(1'b0, `AZFM_OFF_STAT, 32'h0);
		chk("stat keyed", 32'h1, d & 32'h5);
		wp(a);
		// 48000 * 256 / 20.25 samples per cycle
		rng("freq", 606799, 606831, freq_hz);
		// key comes up with the first result, in the same cycle as its strobe
		chk("key", 32'h1, {31'h0, tx_key});
		@(negedge hclk);
		chk("key held", 32'h1, {31'h0, tx_key});
		wp(b);
		rng("gap mins", 60, 61, b - a);
	endtask : t_meas
	task t_minc;
		int a;
		int b;
		bus(1'b1, `AZFM_OFF_MINC, 32'h4);
		bus(1'b1, `AZFM_OFF_MINS, 32'h1);
		wp(a);
		wp(a);
		wp(b);
		rng("gap minc", 80, 82, b - a);
		rng("freq avg", 606799, 606831, freq_hz);
		bus(1'b0, `AZFM_OFF_FREQ, 32'h0);
		rng("freq reg", 606799, 606831, d);
	endtask : t_minc
	task t_fall;
		@(posedge hclk);
		amp <= 23'h600000;
		wait_s(60);
		chk("key hold", 32'h1, {31'h0, tx_key});
		@(posedge hclk);
		amp <= 23'h333333;
		wait_s(60);
		chk("key off", 32'h0, {31'h0, tx_key});
		bus(1'b0, `AZFM_OFF_STAT, 32'h0);
		chk("stat", 32'h0, d & 32'h5);
		bus(1'b0, `AZFM_OFF_CNT, 32'h0);
		chk("count", 32'(npulse), d);
	endtask : t_fall
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_gate();
		t_meas();
		t_minc();
		t_fall();
		stop_test();
	end
endmodule : tb_top
